// file: core/clp_policy.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Dead-battery state commands a fixed 10 mA, ignoring the fast, short and precharge percent fields.
// - Shorted-battery state commands a selectable fixed percentage of fast charge current.
// - Precharge state commands 5 to 20 percent of fast charge current.
// - Input limit equals hardware limit times 7-bit percent code, 1 to 100 percent.
// - Input code is kept as written; zero acts as 1, above 100 acts as 100.
// - Input current flag is high while regulating at the input current limit.
// - Input current regulation runs both safety timers at half rate.
// - Minimum input voltage is 4 V plus 100 mV per code step.
// - Input voltage flag is high while regulating at minimum input voltage.
// - Minimum input voltage regulation runs both safety timers at half rate.
// - Thermal monitor off ignores battery temperature; both algorithms need it zero.
// - Temperature outside limits reports a fault in both modes and halts charging in charge mode.
// - Zoned profile acts only when thermal monitor off and zoned off are zero.
// - Temperature-stopped safety timers hold their counts and resume from them.
// - Below the cold boundary all charging and both timers are suspended.
// - Cool zone fast current follows 2-bit field; code 00 suspends and stops timers.
// - Cool zone codes 01 to 11 leave termination voltage, short and precharge currents unchanged.
// - Warm zone with non-zero voltage field and current bit zero lowers termination by 200 to 750 mV.
// - Warm zone with voltage field 000 and current bit zero halves fast current.
// - Warm zone with current bit one leaves current and voltage unchanged.
// - Above the hot boundary all charging and both timers are suspended.
module clp_policy
	import clp_pkg::*;
#(
	parameter int TICK_CYCLES = CLP_TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           reset,
	// Charger mode and sequencer state
	input  wire logic           charge_mode,
	input  wire logic           reverse_mode,
	input  wire clp_chg_state_e chg_state,
	// Current configuration
	input  wire logic [6:0]     fast_pct_code,
	input  wire logic [1:0]     short_pct_field,
	input  wire logic [1:0]     precharge_pct_field,
	input  wire logic [6:0]     input_limit_pct_code,
	input  wire logic [6:0]     min_vin_code,
	// Regulation loop activity
	input  wire logic           in_current_reg_active,
	input  wire logic           in_voltage_reg_active,
	input  wire logic           die_temp_reg_active,
	// Battery temperature
	input  wire logic [2:0]     battery_temp_input,
	input  wire logic           temp_above_hot,
	input  wire logic           temp_below_cold,
	// Thermal configuration
	input  wire logic           thermal_monitor_off,
	input  wire logic           zoned_profile_off,
	input  wire logic [1:0]     cool_current_field,
	input  wire logic           warm_current_bit,
	input  wire logic [2:0]     warm_voltage_field,
	// Charge command
	output logic                fixed_current_en,
	output logic [7:0]          fixed_current_ma,
	output logic [13:0]         charge_bp,
	output logic [9:0]          vterm_drop_mv,
	// Input limits
	output logic [6:0]          input_limit_pct,
	output logic [14:0]         min_vin_mv,
	// Status
	output logic                in_current_reg_flag,
	output logic                in_voltage_reg_flag,
	output logic                temp_fault,
	output logic                charge_suspend,
	// Safety timer control
	output logic                timers_hold,
	output logic                lowbat_timer_tick,
	output logic                fast_timer_tick
);

	// The divider counts from zero to TICK_CYCLES-1 and gives one base tick per wrap.
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// The zone decode sits in its own module, so the policy sees only exclusive zone flags.
	clp_zone_if zn ();

	clp_zone u_zone (
		.battery_temp_input  (battery_temp_input),
		.temp_above_hot      (temp_above_hot),
		.temp_below_cold     (temp_below_cold),
		.thermal_monitor_off (thermal_monitor_off),
		.zoned_profile_off   (zoned_profile_off),
		.zn                  (zn.zone)
	);

	// Clamps a percent code into 1..100 while the written code itself is left alone.
	function automatic logic [6:0] clamp_pct(input logic [6:0] code);
		logic [6:0] r;
		r = code;
		if (code == 7'h00) begin
			r = CLP_PCT_MIN;
		end else if (code > CLP_PCT_MAX) begin
			r = CLP_PCT_MAX;
		end
		return r;
	endfunction

	// Combinational decode.
	wire [6:0]  fast_eff;
	wire [6:0]  inlim_eff;
	wire [6:0]  short_pct;
	wire [6:0]  pre_pct;
	wire [6:0]  cool_mult;
	wire [6:0]  warm_mult;
	wire [6:0]  fast_mult;
	wire [6:0]  sel_mult;
	wire [13:0] sel_bp;
	wire [13:0] fast_eff_w;
	wire [13:0] sel_mult_w;
	wire [9:0]  warm_drop;
	wire [14:0] vin_mv;
	wire        cool_stop;
	wire        warm_keep;
	wire        warm_reduce_v;
	wire        warm_half_i;
	wire        suspend_all;
	wire        any_reg;
	wire        zone_half;
	wire        lowbat_state;
	wire        fast_state;
	wire        dead_state;

	assign fast_eff  = clamp_pct(fast_pct_code);
	assign inlim_eff = clamp_pct(input_limit_pct_code);

	assign short_pct = 7'h01 << short_pct_field;

	assign pre_pct = (precharge_pct_field == 2'h0) ? CLP_PRE_PCT_0 :
	                 (precharge_pct_field == 2'h1) ? CLP_PRE_PCT_1 :
	                 (precharge_pct_field == 2'h2) ? CLP_PRE_PCT_2 :
	                                                 CLP_PRE_PCT_3;

	// Cool zone only scales fast charge; 00 gives no current at all.
	assign cool_mult = (cool_current_field == 2'h0) ? 7'h00 :
	                   (cool_current_field == 2'h1) ? CLP_PCT_QUARTER :
	                   (cool_current_field == 2'h2) ? CLP_PCT_HALF :
	                                                  CLP_PCT_MAX;
	// Cool 00 also halts short and precharge charging and stops both timers.
	assign cool_stop = zn.cool & (cool_current_field == 2'h0);

	// The current bit overrides the voltage field in the warm zone.
	assign warm_keep     = warm_current_bit;
	assign warm_reduce_v = ~warm_current_bit & (warm_voltage_field != 3'h0);
	// With the voltage field clear the warm zone gives up current instead of voltage.
	assign warm_half_i   = ~warm_current_bit & (warm_voltage_field == 3'h0);
	assign warm_mult     = warm_half_i ? CLP_PCT_HALF : CLP_PCT_MAX;

	assign warm_drop = (!zn.warm || !warm_reduce_v)   ? 10'h000 :
	                   (warm_voltage_field == 3'h1) ? CLP_WARM_DROP_1 :
	                   (warm_voltage_field == 3'h2) ? CLP_WARM_DROP_2 :
	                   (warm_voltage_field == 3'h3) ? CLP_WARM_DROP_3 :
	                   (warm_voltage_field == 3'h4) ? CLP_WARM_DROP_4 :
	                   (warm_voltage_field == 3'h5) ? CLP_WARM_DROP_5 :
	                   (warm_voltage_field == 3'h6) ? CLP_WARM_DROP_6 :
	                                                  CLP_WARM_DROP_7;

	// The zone flags are exclusive, so the order of this selection never matters.
	assign fast_mult = zn.cool ? cool_mult :
	                   zn.warm ? warm_mult :
	                             CLP_PCT_MAX;

	// Short and precharge percentages ignore the cool and warm scaling.
	assign dead_state   = (chg_state == CLP_ST_DEAD);
	// The dead-battery state is counted by the low-battery timer as well.
	assign lowbat_state = (chg_state == CLP_ST_DEAD) |
	                      (chg_state == CLP_ST_SHORT) |
	                      (chg_state == CLP_ST_PRE);
	assign fast_state   = (chg_state == CLP_ST_FAST) |
	                      (chg_state == CLP_ST_FULL);

	assign sel_mult = (chg_state == CLP_ST_SHORT) ? short_pct :
	                  (chg_state == CLP_ST_PRE)   ? pre_pct :
	                  fast_state                  ? fast_mult :
	                                                7'h00;

	// Percent times percent gives hundredths of a percent of the hardware limit.
	// Both factors are widened first so the product keeps all of its bits.
	assign fast_eff_w = 14'(fast_eff);
	assign sel_mult_w = 14'(sel_mult);
	assign sel_bp     = fast_eff_w * sel_mult_w;

	// Cold, hot, simple threshold trip and cool 00 all stop charging.
	assign suspend_all = zn.trip | cool_stop;

	assign vin_mv = CLP_VIN_BASE_MV + 15'(15'(min_vin_code) * CLP_VIN_STEP_MV);

	// Several loops at once still give half rate, never a quarter.
	assign any_reg   = in_current_reg_active |
	                   in_voltage_reg_active |
	                   die_temp_reg_active;
	assign zone_half = (zn.cool & (cool_mult != 7'h00) & (cool_mult != CLP_PCT_MAX)) |
	                   (zn.warm & ~warm_keep);

	// Registered command outputs.
	logic        fixed_en_q;
	logic        fixed_en_d;
	logic [7:0]  fixed_ma_q;
	logic [13:0] bp_q;
	logic [13:0] bp_d;
	logic [9:0]  drop_q;
	logic [9:0]  drop_d;
	logic        halt_d;

	assign halt_d     = charge_mode & suspend_all;
	assign fixed_en_d = charge_mode & dead_state & ~halt_d;
	// Dead state and any halt give zero scaled current; the fixed command takes over in dead state.
	assign bp_d       = (!charge_mode || halt_d || dead_state) ? 14'h0000 : sel_bp;
	// The drop follows the zone even while suspended, so it is right as soon as charging resumes.
	assign drop_d     = charge_mode ? warm_drop : 10'h000;

	always_ff @(posedge clk) begin
		if (reset) begin
			fixed_en_q <= 1'b0;
			fixed_ma_q <= CLP_DEAD_CURRENT_MA;
			bp_q       <= 14'h0000;
			drop_q     <= 10'h000;
		end else begin
			fixed_en_q <= fixed_en_d;
			fixed_ma_q <= CLP_DEAD_CURRENT_MA;
			bp_q       <= bp_d;
			drop_q     <= drop_d;
		end
	end

	// Input limit decode and regulation status.
	// The flags mirror the loops in every mode, so they are visible in reverse mode too.
	logic [6:0]  inlim_q;
	logic [14:0] vin_q;
	logic        icur_flag_q;
	logic        ivolt_flag_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			inlim_q      <= CLP_PCT_MAX;
			vin_q        <= CLP_VIN_BASE_MV;
			icur_flag_q  <= 1'b0;
			ivolt_flag_q <= 1'b0;
		end else begin
			inlim_q      <= inlim_eff;
			vin_q        <= vin_mv;
			icur_flag_q  <= in_current_reg_active;
			ivolt_flag_q <= in_voltage_reg_active;
		end
	end

	// Temperature fault and suspend.
	logic fault_q;
	logic suspend_q;
	wire  fault_d;

	// Reverse mode reports the fault but has no charge command to halt.
	assign fault_d = (charge_mode | reverse_mode) & zn.trip;

	always_ff @(posedge clk) begin
		if (reset) begin
			fault_q   <= 1'b0;
			suspend_q <= 1'b0;
		end else begin
			fault_q   <= fault_d;
			suspend_q <= halt_d;
		end
	end

	// Safety timer rate: a base tick, and a phase bit that passes every other tick.
	// Half rate skips every other base tick; the divider itself never changes speed.
	// A reset restarts the divider and phase, so the first tick follows a full divider period.
	logic [TW-1:0] div_q;
	logic [TW-1:0] div_d;
	logic          phase_q;
	logic          phase_d;
	wire           base_tick;

	assign base_tick = (div_q == TICK_LAST);
	assign div_d     = base_tick ? '0 : TW'(div_q + 1'b1);
	assign phase_d   = base_tick ? ~phase_q : phase_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			div_q   <= '0;
			phase_q <= 1'b0;
		end else begin
			div_q   <= div_d;
			phase_q <= phase_d;
		end
	end

	// Stopped timers get no ticks and keep their count; nothing here clears them.
	// The divider keeps running while held, so counting resumes on the next regular tick.
	wire lowbat_half;
	wire fast_half;
	wire lowbat_tick_d;
	wire fast_tick_d;

	// Zone scaling leaves the low-battery timer at full speed; only the regulation loops slow it.
	assign lowbat_half = any_reg;
	assign fast_half   = any_reg | zone_half;

	assign lowbat_tick_d = charge_mode & lowbat_state & ~halt_d & base_tick &
	                       (~lowbat_half | phase_q);
	assign fast_tick_d   = charge_mode & fast_state & ~halt_d & base_tick &
	                       (~fast_half | phase_q);

	// Ticks are registered so each timer sees a clean one-cycle pulse.
	logic hold_q;
	logic lowbat_tick_q;
	logic fast_tick_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			hold_q        <= 1'b0;
			lowbat_tick_q <= 1'b0;
			fast_tick_q   <= 1'b0;
		end else begin
			hold_q        <= halt_d;
			lowbat_tick_q <= lowbat_tick_d;
			fast_tick_q   <= fast_tick_d;
		end
	end

	// Output ports.
	assign fixed_current_en    = fixed_en_q;
	assign fixed_current_ma    = fixed_ma_q;
	assign charge_bp           = bp_q;
	assign vterm_drop_mv       = drop_q;
	assign input_limit_pct     = inlim_q;
	assign min_vin_mv          = vin_q;
	assign in_current_reg_flag = icur_flag_q;
	assign in_voltage_reg_flag = ivolt_flag_q;
	assign temp_fault          = fault_q;
	assign charge_suspend      = suspend_q;
	assign timers_hold         = hold_q;
	assign lowbat_timer_tick   = lowbat_tick_q;
	assign fast_timer_tick     = fast_tick_q;

endmodule

// file: core/clp_pkg.sv
package clp_pkg;

	// Charge state reported by the charge sequencer.
	typedef enum logic [2:0] {
		CLP_ST_IDLE  = 3'b000,
		CLP_ST_DEAD  = 3'b001,
		CLP_ST_SHORT = 3'b010,
		CLP_ST_PRE   = 3'b011,
		CLP_ST_FAST  = 3'b100,
		CLP_ST_FULL  = 3'b101,
		CLP_ST_TERM  = 3'b110,
		CLP_ST_FAULT = 3'b111
	} clp_chg_state_e;

	// Zone code delivered by the battery temperature comparators.
	typedef enum logic [2:0] {
		CLP_Z_COLD   = 3'b000,
		CLP_Z_COOL   = 3'b001,
		CLP_Z_NORMAL = 3'b010,
		CLP_Z_WARM   = 3'b011,
		CLP_Z_HOT    = 3'b100
	} clp_zone_e;

	localparam logic [7:0]  CLP_DEAD_CURRENT_MA = 8'h0a;
	localparam logic [6:0]  CLP_PCT_MIN         = 7'h01;
	localparam logic [6:0]  CLP_PCT_MAX         = 7'h64;
	localparam logic [6:0]  CLP_PCT_QUARTER     = 7'h19;
	localparam logic [6:0]  CLP_PCT_HALF        = 7'h32;
	localparam logic [14:0] CLP_VIN_BASE_MV     = 15'h0fa0;
	localparam logic [14:0] CLP_VIN_STEP_MV     = 15'h0064;
	localparam logic [6:0]  CLP_PRE_PCT_0       = 7'h05;
	localparam logic [6:0]  CLP_PRE_PCT_1       = 7'h0a;
	localparam logic [6:0]  CLP_PRE_PCT_2       = 7'h0f;
	localparam logic [6:0]  CLP_PRE_PCT_3       = 7'h14;
	localparam logic [9:0]  CLP_WARM_DROP_1     = 10'h0c8;
	localparam logic [9:0]  CLP_WARM_DROP_2     = 10'h12c;
	localparam logic [9:0]  CLP_WARM_DROP_3     = 10'h190;
	localparam logic [9:0]  CLP_WARM_DROP_4     = 10'h1f4;
	localparam logic [9:0]  CLP_WARM_DROP_5     = 10'h258;
	localparam logic [9:0]  CLP_WARM_DROP_6     = 10'h2bc;
	localparam logic [9:0]  CLP_WARM_DROP_7     = 10'h2ee;
	localparam int          CLP_CLK_PERIOD_NS   = 50;
	localparam int          CLP_TICK_PERIOD_NS  = 1000;
	localparam int          CLP_TICK_CYCLES     = CLP_TICK_PERIOD_NS / CLP_CLK_PERIOD_NS;

endpackage

// file: core/clp_zone_if.sv
`timescale 1ns/10ps
interface clp_zone_if;
	logic cold;
	logic cool;
	logic warm;
	logic hot;
	logic trip;
	logic zoned_on;
	modport zone (output cold, cool, warm, hot, trip, zoned_on);
	modport policy (input cold, cool, warm, hot, trip, zoned_on);
endinterface

// file: core/clp_zone.sv
`timescale 1ns/10ps
module clp_zone
	import clp_pkg::*;
(
	// Temperature sense
	input  wire logic [2:0] battery_temp_input,
	input  wire logic       temp_above_hot,
	input  wire logic       temp_below_cold,
	// Configuration
	input  wire logic       thermal_monitor_off,
	input  wire logic       zoned_profile_off,
	// Decoded zones
	clp_zone_if.zone        zn
);
	wire monitor_on;
	wire zoned_on;
	wire code_bad;

	assign monitor_on = ~thermal_monitor_off;
	assign zoned_on   = monitor_on & ~zoned_profile_off;
	// Codes beyond the hot zone are taken as hot so a broken comparator stops charging.
	assign code_bad   = battery_temp_input > CLP_Z_HOT;

	assign zn.zoned_on = zoned_on;
	assign zn.cold     = zoned_on & (battery_temp_input == CLP_Z_COLD);
	assign zn.cool     = zoned_on & (battery_temp_input == CLP_Z_COOL);
	assign zn.warm     = zoned_on & (battery_temp_input == CLP_Z_WARM);
	assign zn.hot      = zoned_on & ((battery_temp_input == CLP_Z_HOT) | code_bad);
	assign zn.trip     = zoned_on ? (zn.cold | zn.hot)
	                              : (monitor_on & (temp_above_hot | temp_below_cold));
endmodule

// file: tb/clp_policy_assertions.sv
`timescale 1ns/10ps
module clp_policy_checker
	import clp_pkg::*;
#(
	parameter int TICK_CYCLES = CLP_TICK_CYCLES
)
(
	// Clock and reset
	input wire logic           clk,
	input wire logic           reset,
	// Watched inputs
	input wire logic           charge_mode,
	input wire clp_chg_state_e chg_state,
	input wire logic [6:0]     input_limit_pct_code,
	input wire logic [6:0]     min_vin_code,
	input wire logic           in_current_reg_active,
	input wire logic           in_voltage_reg_active,
	input wire logic           die_temp_reg_active,
	input wire logic [2:0]     battery_temp_input,
	input wire logic           thermal_monitor_off,
	input wire logic           zoned_profile_off,
	// Watched outputs
	input wire logic           fixed_current_en,
	input wire logic [7:0]     fixed_current_ma,
	input wire logic [6:0]     input_limit_pct,
	input wire logic [14:0]    min_vin_mv,
	input wire logic           in_current_reg_flag,
	input wire logic           in_voltage_reg_flag,
	input wire logic           temp_fault,
	input wire logic           charge_suspend,
	input wire logic           timers_hold,
	input wire logic           lowbat_timer_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	function automatic logic [6:0] pcl(logic [6:0] c);
		return (c == 7'h00) ? 7'h01 : (c > 7'h64) ? 7'h64 : c;
	endfunction
	// Cycles since the last low-battery tick, and whether half rate held all along.
	logic       half;
	logic       half_q;
	logic [7:0] gap_q;
	logic       ok_q;
	logic       seen_q;
	assign half = in_current_reg_active | in_voltage_reg_active | die_temp_reg_active;
	always_ff @(posedge clk) begin
		gap_q <= (reset || lowbat_timer_tick) ? 8'h01 : gap_q + {7'h00, gap_q != 8'hff};
		half_q <= half;
		ok_q <= (reset || lowbat_timer_tick) ? half && half_q && !reset : ok_q && half;
		seen_q <= !reset && (seen_q || lowbat_timer_tick);
	end
	AST_INLIM: assert property (!$past(reset) |-> input_limit_pct == pcl($past(input_limit_pct_code)))
		else $error("input limit percent mismatch");
	AST_MINVIN: assert property (!$past(reset) |-> min_vin_mv == 15'h0fa0 + 15'h0064 * 15'($past(min_vin_code)))
		else $error("minimum input voltage mismatch");
	AST_ICFLAG: assert property (!$past(reset) |-> in_current_reg_flag == $past(in_current_reg_active))
		else $error("input current flag mismatch");
	AST_VFLAG: assert property (!$past(reset) |-> in_voltage_reg_flag == $past(in_voltage_reg_active))
		else $error("input voltage flag mismatch");
	AST_DEAD: assert property (fixed_current_ma == CLP_DEAD_CURRENT_MA &&
		(!fixed_current_en || ($past(chg_state) == CLP_ST_DEAD && $past(charge_mode)))) else $error("dead current mismatch");
	AST_THOFF: assert property ($past(thermal_monitor_off) && !$past(reset) |-> !temp_fault && !charge_suspend)
		else $error("temperature acted while monitor off");
	AST_LIMIT: assert property (!$past(reset) && $past(charge_mode) && !$past(thermal_monitor_off) &&
		!$past(zoned_profile_off) && ($past(battery_temp_input) == 3'h0 || $past(battery_temp_input) >= 3'h4)
		|-> temp_fault && charge_suspend && timers_hold) else $error("out of range zone not suspended");
	AST_HALF: assert property (lowbat_timer_tick && seen_q && ok_q |-> gap_q >= 8'(2 * TICK_CYCLES))
		else $error("low battery timer faster than half rate");
endmodule
bind clp_policy clp_policy_checker #(.TICK_CYCLES(TICK_CYCLES)) clp_policy_checker_inst (.*);

// file: tb/tb_clp_policy.sv
`timescale 1ns/10ps
module tb_clp_policy
	import clp_pkg::*;
;
	typedef struct packed {clp_chg_state_e st; logic [2:0] h; logic [2:0] z; logic [1:0] cf; logic [7:0] n;} clp_tk_s;
	localparam int TC = 2;
	localparam logic [6:0] CN [4] = '{7'h00, 7'h64, 7'h65, 7'h7f};
	// Per run: state, loops active, zone, cool field, ticks expected in 200 cycles.
	localparam clp_tk_s TK [12] = '{'{CLP_ST_PRE, 3'h0, 3'h2, 2'h3, 8'h64}, '{CLP_ST_PRE, 3'h4, 3'h2, 2'h3, 8'h32},
		'{CLP_ST_PRE, 3'h2, 3'h2, 2'h3, 8'h32}, '{CLP_ST_FAST, 3'h7, 3'h2, 2'h3, 8'h32},
		'{CLP_ST_FAST, 3'h0, 3'h1, 2'h1, 8'h32}, '{CLP_ST_FAST, 3'h0, 3'h1, 2'h0, 8'h00},
		'{CLP_ST_PRE, 3'h0, 3'h0, 2'h3, 8'h00}, '{CLP_ST_PRE, 3'h0, 3'h4, 2'h3, 8'h00},
		'{CLP_ST_FAST, 3'h0, 3'h3, 2'h3, 8'h64}, '{CLP_ST_FAST, 3'h0, 3'h2, 2'h3, 8'h64},
		'{CLP_ST_FAST, 3'h0, 3'h3, 2'h3, 8'h32}, '{CLP_ST_PRE, 3'h0, 3'h3, 2'h3, 8'h64}};
	logic clk = 1'b0, reset = 1'b1, charge_mode = 1'b0, reverse_mode = 1'b0;
	clp_chg_state_e chg_state = CLP_ST_IDLE;
	logic [6:0] fast_pct_code = 7'h00, input_limit_pct_code = 7'h00, min_vin_code = 7'h00;
	logic [1:0] short_pct_field = 2'h0, precharge_pct_field = 2'h0, cool_current_field = 2'h0;
	logic in_current_reg_active = 1'b0, in_voltage_reg_active = 1'b0, die_temp_reg_active = 1'b0;
	logic [2:0] battery_temp_input = 3'h2, warm_voltage_field = 3'h0;
	logic temp_above_hot = 1'b0, temp_below_cold = 1'b0, warm_current_bit = 1'b0;
	logic thermal_monitor_off = 1'b0, zoned_profile_off = 1'b0;
	logic fixed_current_en, in_current_reg_flag, in_voltage_reg_flag, temp_fault, charge_suspend;
	logic timers_hold, lowbat_timer_tick, fast_timer_tick;
	logic [7:0] fixed_current_ma;
	logic [13:0] charge_bp, e_bp;
	logic [9:0] vterm_drop_mv, e_dr;
	logic [6:0] input_limit_pct, e_pc;
	logic [14:0] min_vin_mv, e_vn;
	logic e_ic, e_iv, e_ft, e_su, e_fx, e_cm, zo;
	logic [15:0] nt;
	int err_count = 0, n_checks = 0;
	clp_policy #(.TICK_CYCLES(TC)) clp_policy_inst (.*);
	always #25 clk = ~clk;
	function automatic logic [6:0] pc(logic [6:0] c);
		return (c == 7'h00) ? 7'h01 : (c > 7'h64) ? 7'h64 : c;
	endfunction
	function automatic logic [6:0] pk();
		return ($urandom % 3 == 0) ? CN[$urandom % 4] : 7'($urandom);
	endfunction
	function automatic logic tp();
		if (thermal_monitor_off) return 1'b0;
		if (!zoned_profile_off) return battery_temp_input == 3'h0 || battery_temp_input >= 3'h4;
		return temp_above_hot || temp_below_cold;
	endfunction
	function automatic logic [6:0] ml();
		case (chg_state)
			CLP_ST_SHORT: return 7'h01 << short_pct_field;
			CLP_ST_PRE: return 7'h05 * (7'h01 + 7'(precharge_pct_field));
			CLP_ST_FAST, CLP_ST_FULL: begin
				if (zo && battery_temp_input == 3'h1)
					return (cool_current_field == 2'h3) ? 7'h64 : 7'h19 * 7'(cool_current_field);
				if (zo && battery_temp_input == 3'h3 && !warm_current_bit && warm_voltage_field == 3'h0)
					return 7'h32;
				return 7'h64;
			end
			default: return 7'h00;
		endcase
	endfunction
	function automatic logic [9:0] dr();
		if (!zo || battery_temp_input != 3'h3 || warm_current_bit || warm_voltage_field == 3'h0) return 10'h000;
		return (warm_voltage_field == 3'h7) ? 10'h2ee : 10'h064 * (10'h001 + 10'(warm_voltage_field));
	endfunction
	task automatic chk(logic [15:0] g, logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rnd();
		charge_mode <= ($urandom % 8) != 0;
		reverse_mode <= 1'($urandom);
		chg_state <= clp_chg_state_e'(3'($urandom));
		fast_pct_code <= pk();
		short_pct_field <= 2'($urandom);
		precharge_pct_field <= 2'($urandom);
		input_limit_pct_code <= pk();
		min_vin_code <= 7'($urandom);
		{in_current_reg_active, in_voltage_reg_active, die_temp_reg_active} <= 3'($urandom);
		battery_temp_input <= 3'($urandom);
		{temp_above_hot, temp_below_cold, warm_current_bit} <= 3'($urandom);
		thermal_monitor_off <= ($urandom % 4) == 0;
		zoned_profile_off <= ($urandom % 4) == 0;
		cool_current_field <= 2'($urandom);
		warm_voltage_field <= 3'($urandom);
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(50 * 20000);
		err_count++;
		end_sim();
	end
	initial begin
		void'($urandom(32'hf316));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			zo = !thermal_monitor_off && !zoned_profile_off;
			e_cm = charge_mode;
			e_bp = 14'(pc(fast_pct_code)) * 14'(ml());
			e_dr = dr();
			e_pc = pc(input_limit_pct_code);
			e_vn = 15'h0fa0 + 15'h0064 * 15'(min_vin_code);
			{e_ic, e_iv} = {in_current_reg_active, in_voltage_reg_active};
			e_ft = (charge_mode || reverse_mode) && tp();
			e_su = charge_mode && (tp() || (zo && battery_temp_input == 3'h1 && cool_current_field == 2'h0));
			e_fx = charge_mode && chg_state == CLP_ST_DEAD && !e_su;
			rnd();
			@(negedge clk);
			chk(16'(input_limit_pct), 16'(e_pc));
			chk(16'(min_vin_mv), 16'(e_vn));
			chk(16'(in_current_reg_flag), 16'(e_ic));
			chk(16'(in_voltage_reg_flag), 16'(e_iv));
			chk(16'(temp_fault), 16'(e_ft));
			chk(16'(charge_suspend), 16'(e_su));
			chk(16'(timers_hold), 16'(e_su));
			chk(16'(fixed_current_ma), 16'h000a);
			chk(16'(charge_bp), (e_cm && !e_su) ? 16'(e_bp) : 16'h0000);
			chk(16'(vterm_drop_mv), e_cm ? 16'(e_dr) : 16'h0000);
			chk(16'(fixed_current_en), 16'(e_fx));
		end
		$display("Random policy test done");
		@(posedge clk);
		{charge_mode, reverse_mode, thermal_monitor_off, zoned_profile_off, warm_current_bit} <= 5'h11;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			chg_state <= TK[k].st;
			{in_current_reg_active, in_voltage_reg_active, die_temp_reg_active} <= TK[k].h;
			battery_temp_input <= TK[k].z;
			cool_current_field <= TK[k].cf;
			warm_current_bit <= (k < 10);
			repeat (8) @(posedge clk);
			nt = 16'h0000;
			repeat (200) begin
				@(negedge clk);
				nt = nt + 16'((TK[k].st == CLP_ST_PRE) ? lowbat_timer_tick : fast_timer_tick);
			end
			chk(nt, 16'(TK[k].n));
			$display("Timer rate run %0d done", k);
		end
		end_sim();
	end
endmodule
